/* logic/umspi_baud.sv */
// Purpose: baud tick generator
// Assumes: divider stable while running
// Notes:   tick every divider+1 clocks gives half periods
`timescale 1ns/100ps
`include "umspi_regs.svh"
module umspi_baud (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // control
  input  wire logic                    run,
  input  wire logic [`UMSPI_DIV_W-1:0] divider,
  // output
  output logic                         tick
);
  logic [`UMSPI_DIV_W-1:0] cnt_q;
  logic [`UMSPI_DIV_W-1:0] cnt_d;

  always_comb begin
    tick  = 1'b0;
    cnt_d = `UMSPI_DIV_RESET;
    if (run) begin
      if (cnt_q >= divider) begin
        tick = 1'b1;
      end else begin
        cnt_d = cnt_q + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= `UMSPI_DIV_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : umspi_baud

/* logic/umspi_core.sv */
// Purpose: master spi transfer control on a uart port
// Assumes: software keeps format stable during transfers
// Notes:   no slave select; select lines live outside
`timescale 1ns/100ps
`include "umspi_regs.svh"
module umspi_core (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // configuration
  input  wire umspi_pkg::umspi_cfg_type cfg,
  // data buffer access
  input  wire logic                     data_write,
  input  wire logic [7:0]               data_wdata,
  input  wire logic                     data_read,
  output logic [7:0]                    data_rdata,
  // flag control
  input  wire logic                     tx_complete_clear,
  output umspi_pkg::umspi_status_type   status,
  // pins
  input  wire logic                     serial_in_pin,
  output logic                          serial_out_pin,
  output logic                          serial_out_oe,
  output logic                          transfer_clock_pin,
  output logic                          transfer_clock_oe
);
  logic                        sin_s1_q;
  logic                        sin_s2_q;
  logic                        sin_s3_q;
  logic                        sin_q;
  logic                        sin_d;
  umspi_pkg::umspi_state_type  st_q;
  umspi_pkg::umspi_state_type  st_d;
  logic [7:0]                  txbuf_q;
  logic [7:0]                  txbuf_d;
  logic                        txfull_q;
  logic                        txfull_d;
  logic [7:0]                  shtx_q;
  logic [7:0]                  shtx_d;
  logic [7:0]                  shrx_q;
  logic [7:0]                  shrx_d;
  logic [`UMSPI_BIT_CNT_W-1:0] bit_q;
  logic [`UMSPI_BIT_CNT_W-1:0] bit_d;
  logic                        sck_q;
  logic                        sck_d;
  logic                        sout_q;
  logic                        sout_d;
  logic                        txc_q;
  logic                        txc_d;
  logic                        rxpush;
  logic [7:0]                  rxbyte;
  logic                        rx_ne;
  logic [7:0]                  rx_head;
  logic                        tick;
  logic                        running;

  // bit selected for output from shift register by order
  function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
    out_bit = lsb_first ? v[0] : v[7];
  endfunction : out_bit

  // shift in at the side opposite to output
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsb_first);
    shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  // input passes three stages; the value moves once stages two and three agree
  always_comb begin
    sin_d = sin_q;
    if (sin_s2_q == sin_s3_q) begin
      sin_d = sin_s3_q;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sin_s1_q <= 1'b1;
      sin_s2_q <= 1'b1;
      sin_s3_q <= 1'b1;
      sin_q    <= 1'b1;
    end else begin
      sin_s1_q <= serial_in_pin;
      sin_s2_q <= sin_s1_q;
      sin_s3_q <= sin_s2_q;
      sin_q    <= sin_d;
    end
  end

  assign running = (st_q != umspi_pkg::umspi_idle);

  umspi_baud u_baud (
    .mclk    (mclk),
    .rst     (rst),
    .run     (running),
    .divider (cfg.baud_divider),
    .tick    (tick)
  );

  always_comb begin
    st_d    = st_q;
    txbuf_d = txbuf_q;
    txfull_d = txfull_q;
    shtx_d  = shtx_q;
    shrx_d  = shrx_q;
    bit_d   = bit_q;
    sck_d   = sck_q;
    sout_d  = sout_q;
    txc_d   = txc_q;
    rxpush  = 1'b0;
    rxbyte  = shrx_q;
    if (tx_complete_clear) begin
      txc_d = 1'b0;
    end
    // writes only count while the transmitter runs the clock
    if (data_write && cfg.transmitter_enable && !txfull_q) begin
      txbuf_d  = data_wdata;
      txfull_d = 1'b1;
    end
    unique case (st_q)
      umspi_pkg::umspi_idle: begin
        sck_d  = cfg.clock_polarity_bit;
        sout_d = 1'b1;
        if (txfull_q && cfg.transmitter_enable) begin
          shtx_d   = txbuf_q;
          txfull_d = txfull_d & data_write & ~txfull_q;
          bit_d    = `UMSPI_BIT_CNT_W'(0);
          st_d     = umspi_pkg::umspi_lead;
          // phase 0 sets up the first bit before the leading edge
          if (!cfg.clock_phase_bit) begin
            sout_d = out_bit(txbuf_q, cfg.bit_order_select);
          end
        end
      end
      umspi_pkg::umspi_lead: begin
        if (tick) begin
          sck_d = ~cfg.clock_polarity_bit;
          st_d  = umspi_pkg::umspi_trail;
          if (cfg.clock_phase_bit) begin
            sout_d = out_bit(shtx_q, cfg.bit_order_select);
          end else begin
            shrx_d = shift_in(shrx_q, sin_q, cfg.bit_order_select);
          end
        end
      end
      umspi_pkg::umspi_trail: begin
        if (tick) begin
          sck_d = cfg.clock_polarity_bit;
          if (cfg.clock_phase_bit) begin
            shrx_d = shift_in(shrx_q, sin_q, cfg.bit_order_select);
          end
          shtx_d = cfg.bit_order_select ? {1'b0, shtx_q[7:1]} : {shtx_q[6:0], 1'b0};
          if (bit_q == `UMSPI_LAST_BIT) begin
            rxbyte = cfg.clock_phase_bit ?
                     shift_in(shrx_q, sin_q, cfg.bit_order_select) : shrx_q;
            rxpush = cfg.receiver_enable;
            if (txfull_q) begin
              shtx_d   = txbuf_q;
              txfull_d = 1'b0;
              bit_d    = `UMSPI_BIT_CNT_W'(0);
              st_d     = umspi_pkg::umspi_lead;
              sout_d   = cfg.clock_phase_bit ? sout_q
                         : out_bit(txbuf_q, cfg.bit_order_select);
            end else begin
              txc_d  = 1'b1;
              // phase 1 samples on this edge: hold last bit, idle raises it next cycle
              sout_d = cfg.clock_phase_bit ? sout_q : 1'b1;
              st_d   = umspi_pkg::umspi_idle;
            end
          end else begin
            bit_d = bit_q + `UMSPI_BIT_CNT_W'(1);
            st_d  = umspi_pkg::umspi_lead;
            if (!cfg.clock_phase_bit) begin
              sout_d = cfg.bit_order_select ? shtx_q[1] : shtx_q[6];
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q     <= umspi_pkg::umspi_idle;
      txbuf_q  <= `UMSPI_BYTE_RESET;
      txfull_q <= 1'b0;
      shtx_q   <= `UMSPI_BYTE_RESET;
      shrx_q   <= `UMSPI_BYTE_RESET;
      bit_q    <= `UMSPI_BIT_CNT_W'(0);
      sck_q    <= 1'b0;
      sout_q   <= 1'b1;
      txc_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      txbuf_q  <= txbuf_d;
      txfull_q <= txfull_d;
      shtx_q   <= shtx_d;
      shrx_q   <= shrx_d;
      bit_q    <= bit_d;
      sck_q    <= sck_d;
      sout_q   <= sout_d;
      txc_q    <= txc_d;
    end
  end

  umspi_rxbuf u_rxbuf (
    .mclk      (mclk),
    .rst       (rst),
    .push      (rxpush),
    .push_data (rxbyte),
    .pop       (data_read),
    .head_data (rx_head),
    .not_empty (rx_ne)
  );

  assign data_rdata         = rx_head;
  assign serial_out_pin     = sout_q;
  assign serial_out_oe      = cfg.transmitter_enable;
  assign transfer_clock_pin = sck_q;
  assign transfer_clock_oe  = cfg.transmitter_enable;

  always_comb begin
    status.receive_complete_flag  = rx_ne;
    status.transmit_complete_flag = txc_q;
    status.buffer_empty_flag      = ~txfull_q;
    status.framing_error_flag     = 1'b0;
    status.receive_overrun_flag   = 1'b0;
    status.parity_error_flag      = 1'b0;
  end
endmodule : umspi_core

/* logic/umspi_pkg.sv */
// Purpose: shared types for the master spi transfer block
// Assumes: umspi_regs.svh included for widths
// Notes:   config and status travel as packed structs
`include "umspi_regs.svh"
package umspi_pkg;
  typedef struct packed {
    logic                    transmitter_enable;
    logic                    receiver_enable;
    logic                    bit_order_select;
    logic                    clock_polarity_bit;
    logic                    clock_phase_bit;
    logic [`UMSPI_DIV_W-1:0] baud_divider;
  } umspi_cfg_type;

  typedef struct packed {
    logic receive_complete_flag;
    logic transmit_complete_flag;
    logic buffer_empty_flag;
    logic framing_error_flag;
    logic receive_overrun_flag;
    logic parity_error_flag;
  } umspi_status_type;

  typedef enum logic [1:0] {
    umspi_idle,
    umspi_lead,
    umspi_trail
  } umspi_state_type;
endpackage : umspi_pkg

/* logic/umspi_regs.svh */
// Purpose: constants for the master spi transfer block
// Assumes: 20 MHz mclk, byte frames
// Notes:   rule overview below
// Overview of operation
// - every frame carries exactly eight data bits, msb or lsb first
// - after a frame, start the next queued one or idle serial out high
// - one bit order select governs both transmitter and receiver
// - two back to back bytes give sixteen bits; complete flag after both
// - receiver never runs alone; transmitter generates the clock
// - baud divider resets to zero
// - transmitter enable makes serial out carry shift data
// - receiver enable takes serial in as receive data
// - transfer clock pin is the shift clock in every case
// - every transfer, even receive only, starts on a data write
// - written byte waits in transmit buffer until shifter is free
// - on overflow the newest received byte is dropped, older kept
// - receive, transmit complete and buffer empty flags as in uart mode
// - framing, overrun and parity flags always read zero
// - transmitter double buffered, receiver two levels, no collision flag
// - master only, no slave select
// - polarity and phase choose the four spi modes
// - transfer clock is system clock over two times (divider plus one)
`ifndef UMSPI_REGS_SVH
`define UMSPI_REGS_SVH
`define UMSPI_FRAME_BITS   4'h8
`define UMSPI_BIT_CNT_W    4
`define UMSPI_DIV_W        12
`define UMSPI_DIV_RESET    12'h000
`define UMSPI_BYTE_RESET   8'h00
`define UMSPI_RX_DEPTH     2
`define UMSPI_LAST_BIT     4'h7
`endif

/* logic/umspi_rxbuf.sv */
// Purpose: two level receive buffer
// Assumes: one push per frame, pop on data read
// Notes:   full buffer drops the incoming byte
`timescale 1ns/100ps
`include "umspi_regs.svh"
module umspi_rxbuf (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // fill side
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  // drain side
  input  wire logic       pop,
  output logic [7:0]      head_data,
  output logic            not_empty
);
  logic [7:0] mem_q [`UMSPI_RX_DEPTH];
  logic [7:0] mem_d [`UMSPI_RX_DEPTH];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    if (pop && cnt_q != 2'h0) begin
      mem_d[0] = mem_q[1];
      cnt_d    = cnt_q - 2'h1;
    end
    // full and no room freed: newest byte is lost
    if (push && cnt_d != 2'(`UMSPI_RX_DEPTH)) begin
      mem_d[cnt_d[0]] = push_data;
      cnt_d           = cnt_d + 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_q[0] <= `UMSPI_BYTE_RESET;
      mem_q[1] <= `UMSPI_BYTE_RESET;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
    end
  end

  assign head_data = mem_q[0];
  assign not_empty = (cnt_q != 2'h0);
endmodule : umspi_rxbuf

/* testbench/umspi_checker.sv */
// Purpose: port assertions for umspi_core
// Assumes: single mclk domain
// Notes:   bound from the bench top file
`timescale 1ns/100ps
module umspi_checker (
  // clock and reset
  input wire logic                        mclk,
  input wire logic                        rst,
  // control side
  input wire umspi_pkg::umspi_cfg_type    cfg,
  input wire logic                        data_write,
  input wire umspi_pkg::umspi_status_type status,
  // pins
  input wire logic                        serial_out_pin,
  input wire logic                        serial_out_oe,
  input wire logic                        transfer_clock_pin,
  input wire logic                        transfer_clock_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic        sck_q, sck_d;
  logic [11:0] gap_q, gap_d;
  // saturates so long idle gaps never wrap below the divider
  always_comb begin
    sck_d = transfer_clock_pin;
    gap_d = (transfer_clock_pin != sck_q) ? 12'h000 : gap_q + {11'h000, gap_q != 12'hFFF};
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'h0;
      gap_q <= 12'hFFF;
    end else begin
      sck_q <= sck_d;
      gap_q <= gap_d;
    end
  end
  property p_err_zero;
    !(status.framing_error_flag | status.receive_overrun_flag | status.parity_error_flag);
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error flag set");
  property p_sout_oe;
    serial_out_oe == cfg.transmitter_enable;
  endproperty
  a_sout_oe: assert property (p_sout_oe) else $error("serial out enable wrong");
  property p_sck_oe;
    transfer_clock_oe == cfg.transmitter_enable;
  endproperty
  a_sck_oe: assert property (p_sck_oe) else $error("clock enable wrong");
  property p_idle_high;
    $rose(status.transmit_complete_flag) |=> serial_out_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("serial out not idle");
  property p_idle_pol;
    $rose(status.transmit_complete_flag) |-> transfer_clock_pin == cfg.clock_polarity_bit;
  endproperty
  a_idle_pol: assert property (p_idle_pol) else $error("clock idle level wrong");
  property p_txc_last;
    $rose(status.transmit_complete_flag) |-> status.buffer_empty_flag;
  endproperty
  a_txc_last: assert property (p_txc_last) else $error("complete with byte queued");
  property p_queue;
    $fell(status.buffer_empty_flag) |-> $past(data_write);
  endproperty
  a_queue: assert property (p_queue) else $error("buffer filled without write");
  property p_half;
    (transfer_clock_pin != sck_q) && cfg.transmitter_enable |-> gap_q >= cfg.baud_divider;
  endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_no_tx;
    !cfg.transmitter_enable && !$past(cfg.transmitter_enable) |-> $stable(transfer_clock_pin);
  endproperty
  a_no_tx: assert property (p_no_tx) else $error("clock moved while disabled");
  property p_rxc;
    $rose(status.receive_complete_flag) |-> transfer_clock_pin == cfg.clock_polarity_bit;
  endproperty
  a_rxc: assert property (p_rxc) else $error("receive flag mid frame");
  c_txc: cover property ($rose(status.transmit_complete_flag));
  c_rxc: cover property ($rose(status.receive_complete_flag));
  c_lsb: cover property ($rose(status.transmit_complete_flag) && cfg.bit_order_select);
endmodule : umspi_checker

/* testbench/umspi_slave.sv */
// Purpose: behavioural spi slave on the far side
// Assumes: always selected, load pulse before each transfer
// Notes:   undriven first bit shows inverse to expose stale sampling
`timescale 1ns/100ps
module umspi_slave (
  input wire logic       sck,
  input wire logic       mosi,
  input wire logic       load,
  input wire logic       cpha,
  input wire logic       lsb,
  input wire logic [7:0] tx_byte,
  output logic           miso,
  output int             edges,
  output logic [7:0]     rx_byte,
  output realtime        t_first,
  output realtime        t_last
);
  int i;
  int j;
  always @(sck or posedge load) begin
    if (load) begin
      edges = 0;
    end else begin
      if (edges == 0) t_first = $realtime;
      t_last = $realtime;
      i = (edges / 2) % 8;
      if ((edges % 2) == cpha) rx_byte[lsb ? i : 7 - i] = mosi;
      edges++;
    end
  end
  always_comb begin
    j = ((edges - cpha) / 2) % 8;
    miso = (edges < cpha) ? ~tx_byte[lsb ? 0 : 7] : tx_byte[lsb ? j : 7 - j];
  end
endmodule : umspi_slave

/* testbench/umspi_tb_top.sv */
// Purpose: self checking bench for umspi_core
// Assumes: divider 4 leaves room for the input synchroniser
// Notes:   slave byte reloaded per transfer; the back to back pair shares one load
`timescale 1ns/100ps
module umspi_tb_top;
  logic                        mclk, rst, data_write, data_read, tx_complete_clear, load;
  logic [7:0]                  data_wdata, data_rdata, s_tx, s_rx;
  logic                        sout, sout_oe, sck, sck_oe, miso;
  umspi_pkg::umspi_cfg_type    cfg;
  umspi_pkg::umspi_status_type status;
  int                          n_errors, checks_done, edges;
  realtime                     t0, t1;
  umspi_core DUT (.mclk, .rst, .cfg, .data_write, .data_wdata, .data_read, .data_rdata,
    .tx_complete_clear, .status, .serial_in_pin(miso), .serial_out_pin(sout),
    .serial_out_oe(sout_oe), .transfer_clock_pin(sck), .transfer_clock_oe(sck_oe));
  umspi_slave SLV (.sck, .mosi(sout), .load, .cpha(cfg.clock_phase_bit),
    .lsb(cfg.bit_order_select), .tx_byte(s_tx), .miso, .edges, .rx_byte(s_rx),
    .t_first(t0), .t_last(t1));
  always #25 mclk = ~mclk;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc
  task automatic reload(logic [7:0] b);
    s_tx = b;
    load = 1'h1;
    cyc(1);
    load = 1'h0;
  endtask : reload
  // clear complete first so it marks only this transfer
  task automatic send(logic [7:0] b);
    int k;
    k = 0;
    while (status.buffer_empty_flag !== 1'h1 && k < 5000) begin
      cyc(1);
      k++;
    end
    tx_complete_clear = 1'h1;
    cyc(1);
    tx_complete_clear = 1'h0;
    data_wdata = b;
    data_write = 1'h1;
    cyc(1);
    data_write = 1'h0;
  endtask : send
  task automatic wait_txc;
    int k;
    k = 0;
    while (status.transmit_complete_flag !== 1'h1 && k < 5000) begin
      cyc(1);
      k++;
    end
    chk("tx complete", 16'h0001, status.transmit_complete_flag);
  endtask : wait_txc
  task automatic pop(logic [7:0] exp);
    chk("read data", exp, data_rdata);
    data_read = 1'h1;
    cyc(1);
    data_read = 1'h0;
  endtask : pop
  task automatic t_reset;
    chk("status", 16'h0008, status);
    chk("serial out", 16'h0001, sout);
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes;
    logic [7:0] b;
    for (int m = 0; m < 8; m++) begin
      // idle clock level moves with polarity; keep it clear of the last edge
      cyc(5);
      cfg.clock_polarity_bit = m[0];
      cfg.clock_phase_bit = m[1];
      cfg.bit_order_select = m[2];
      cyc(2);
      b = 8'h35 + 8'(m * 16'h0013);
      reload(~b);
      send(b);
      wait_txc;
      chk("slave byte", b, s_rx);
      chk("edges", 16'h0010, 16'(edges));
      chk("span", 16'h004B, 16'(int'((t1 - t0) / 50.0)));
      pop(~b);
      chk("rx flag", 16'h0000, status.receive_complete_flag);
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_pair;
    reload(8'hC3);
    send(8'h81);
    send(8'h7E);
    chk("tx complete early", 16'h0000, status.transmit_complete_flag);
    wait_txc;
    chk("edges", 16'h0020, 16'(edges));
    chk("slave byte", 16'h007E, s_rx);
    pop(8'hC3);
    pop(8'hC3);
    $display("test pair done");
  endtask : t_pair
  task automatic t_over;
    for (int f = 0; f < 4; f++) begin
      reload(8'h10 + 8'(f));
      send(8'h5A);
      wait_txc;
    end
    pop(8'h10);
    pop(8'h11);
    chk("rx flag", 16'h0000, status.receive_complete_flag);
    $display("test overflow done");
  endtask : t_over
  task automatic t_off;
    cfg.receiver_enable = 1'h0;
    reload(8'h66);
    send(8'h99);
    wait_txc;
    chk("rx flag", 16'h0000, status.receive_complete_flag);
    cfg.transmitter_enable = 1'h0;
    cyc(2);
    reload(8'h66);
    send(8'h99);
    cyc(40);
    chk("edges", 16'h0000, 16'(edges));
    chk("out enable", 16'h0000, sout_oe);
    chk("tx complete", 16'h0000, status.transmit_complete_flag);
    $display("test disabled done");
  endtask : t_off
  initial begin
    mclk = 1'h0;
    rst = 1'h1;
    load = 1'h0;
    data_write = 1'h0;
    data_read = 1'h0;
    data_wdata = 8'h00;
    tx_complete_clear = 1'h0;
    s_tx = 8'h00;
    cfg = '0;
    cfg.transmitter_enable = 1'h1;
    cfg.receiver_enable = 1'h1;
    repeat (5) @(posedge mclk);
    #2 rst = 1'h0;
    t_reset;
    cfg.baud_divider = 12'h004;
    cyc(2);
    t_modes;
    t_pair;
    t_over;
    t_off;
    finish_test;
  end
  initial begin
    #2000000;
    n_errors++;
    finish_test;
  end
endmodule : umspi_tb_top
bind umspi_core umspi_checker u_chk (.mclk, .rst, .cfg, .data_write, .status,
  .serial_out_pin, .serial_out_oe, .transfer_clock_pin, .transfer_clock_oe);
